// ==== lirq_defs.svh ====
// register offsets, field positions and reset values of the local interrupt logic
// assumes full 32-bit byte addresses on the core register port
`ifndef LIRQ_DEFS_SVH
`define LIRQ_DEFS_SVH

`define LIRQ_OFS_EOS        32'hfee000b0
`define LIRQ_OFS_VERSION    32'hfee00030
`define LIRQ_OFS_TPR        32'hfee00080
`define LIRQ_OFS_SVR        32'hfee000f0

`define LIRQ_SVR_VEC_LSB    0
`define LIRQ_SVR_VEC_MSB    7
`define LIRQ_SVR_ENABLE     8
`define LIRQ_SVR_FOCUS      9
`define LIRQ_SVR_SUPPRESS   12
`define LIRQ_VER_SUPPRESS   24

`define LIRQ_RST_TPR        8'h00
`define LIRQ_RST_SPUR_VEC   8'hff
`define LIRQ_RST_ENABLE     1'b1
`define LIRQ_RST_FOCUS      1'b0
`define LIRQ_RST_SUPPRESS   1'b0
`define LIRQ_OLD_LOW_ONES   4'hf
`define LIRQ_FIRST_VECTOR   8'h10

`endif

// ==== lirq_pkg.sv ====
// types shared by the local interrupt completion and priority logic
// constants live in lirq_defs.svh
package lirq_pkg;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } lirq_reg_req_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [1:0]  cpl;
    logic [63:0] wdata;
  } lirq_alias_req_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] vector;
    logic       level;
  } lirq_accept_type;

  typedef struct packed {
    logic [255:0] pending;
    logic [255:0] in_service;
    logic [255:0] trig_mode;
    logic [7:0]   task_priority_threshold;
    logic [7:0]   spur_vec;
    logic         sw_enable;
    logic         focus_chk;
    logic         suppress;
    logic [31:0]  rdata;
    logic         rvalid;
    logic [63:0]  alias_rdata;
    logic         alias_done;
    logic         alias_fault;
    logic         irq_req;
    logic [7:0]   ack_vector;
    logic         ack_valid;
    logic         ack_spurious;
    logic         bcast_valid;
    logic [7:0]   bcast_vector;
  } lirq_state_type;

endpackage

// ==== lirq_top_bit.sv ====
// finds the highest set bit of a vector and its index
// purely combinational, used by the main block on its own clock
`timescale 1ns/10ps
module lirq_top_bit #(
  parameter int WIDTH = 256,
  parameter int IDXW  = 8
) (
  input  wire logic [WIDTH-1:0] bits,
  output logic                  found,
  output logic [IDXW-1:0]       index
);

  logic [WIDTH:0] above;

  assign above[WIDTH] = 1'b0;

  // each bit wins only if no higher bit is set
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_chain
      assign above[i] = above[i+1] | bits[i];
    end
  endgenerate

  always_comb begin
    index = '0;
    for (int j = 0; j < WIDTH; j++) begin
      if (bits[j] && !above[j+1]) begin
        index = IDXW'(j);
      end
    end
  end

  assign found = above[0];

endmodule

// ==== lirq_core.sv ====
// local interrupt controller: completion, task priority, alias and spurious vector
// assumes requests arrive from logic on clk_sys and last one cycle each
// assumes core and routing logic share clk_sys, so no synchronisers
// limitation: one acknowledge in flight, answered the next cycle
`timescale 1ns/10ps
`include "lirq_defs.svh"
module lirq_core #(
  parameter bit         NEW_VARIANT      = 1'b1,
  parameter bit         SUPPRESS_SUPPORT = 1'b1,
  parameter logic [7:0] VERSION_ID       = 8'h15
) (
  input  wire logic                         clk_sys,
  input  wire logic                         sys_rst,
  input  wire lirq_pkg::lirq_reg_req_type   reg_req,
  output logic [31:0]                       reg_rdata,
  output logic                              reg_rvalid,
  input  wire lirq_pkg::lirq_alias_req_type alias_req,
  output logic [63:0]                       alias_rdata,
  output logic                              alias_done,
  output logic                              alias_fault,
  input  wire lirq_pkg::lirq_accept_type    accept,
  input  wire logic                         core_acknowledge_cycle,
  output logic                              core_interrupt_request,
  output logic [7:0]                        ack_vector,
  output logic                              ack_valid,
  output logic                              ack_spurious,
  output logic                              eos_bcast_valid,
  output logic [7:0]                        eos_bcast_vector,
  output logic                              controller_enabled,
  output logic                              focus_check_enable
);

  lirq_pkg::lirq_state_type state_q;
  lirq_pkg::lirq_state_type state_d;

  logic       pend_found;
  logic [7:0] pend_top;
  logic       serv_found;
  logic [7:0] serv_top;
  logic [7:0] current_processor_priority;
  logic       deliverable;
  logic       eos_wr;
  logic [7:0] wvec;
  logic       alias_ok;
  logic [3:0] tpr_class;
  logic [3:0] serv_class;
  logic [3:0] pend_class;
  logic       alias_priv_ok;
  logic       alias_resv_ok;
  logic       level_done;
  logic       bcast_go;
  logic       ack_take;

  lirq_top_bit #(
    .WIDTH (256),
    .IDXW  (8)
  ) u_pend_top (
    .bits  (state_q.pending),
    .found (pend_found),
    .index (pend_top)
  );

  lirq_top_bit #(
    .WIDTH (256),
    .IDXW  (8)
  ) u_serv_top (
    .bits  (state_q.in_service),
    .found (serv_found),
    .index (serv_top)
  );

  assign tpr_class  = state_q.task_priority_threshold[7:4];
  assign serv_class = serv_top[7:4];
  assign pend_class = pend_top[7:4];

  // processor priority: threshold or top in-service class, whichever is higher
  always_comb begin
    if (!serv_found || tpr_class >= serv_class) begin
      current_processor_priority = state_q.task_priority_threshold;
    end else begin
      current_processor_priority = {serv_class, 4'h0};
    end
  end

  assign deliverable = state_q.sw_enable && pend_found && (pend_class > current_processor_priority[7:4]);

  // acknowledge meets something deliverable, so a real vector goes out
  assign ack_take = core_acknowledge_cycle && deliverable;

  assign eos_wr = reg_req.wr && (reg_req.addr == `LIRQ_OFS_EOS);

  // older variant keeps low nibble at ones
  assign wvec = NEW_VARIANT ? reg_req.wdata[`LIRQ_SVR_VEC_MSB:`LIRQ_SVR_VEC_LSB]
                            : {reg_req.wdata[7:4], `LIRQ_OLD_LOW_ONES};

  assign alias_priv_ok = (alias_req.cpl == 2'b00);
  // upper bits must be zero on write
  assign alias_resv_ok = !(alias_req.wr && (alias_req.wdata[63:4] != 60'h0));
  // alias dead while disabled, enable tested where it acts
  assign alias_ok      = alias_priv_ok && alias_resv_ok;

  // completing a level source owes the remote controllers a message
  assign level_done = eos_wr && serv_found && state_q.trig_mode[serv_top];
  assign bcast_go   = level_done && !state_q.suppress;

  always_comb begin
    state_d              = state_q;
    state_d.rvalid       = 1'b0;
    state_d.alias_done   = 1'b0;
    state_d.alias_fault  = 1'b0;
    state_d.ack_valid    = 1'b0;
    state_d.ack_spurious = 1'b0;
    state_d.bcast_valid  = 1'b0;

    // vectors below the first usable one are reserved and dropped
    // trigger bit tracks source type
    if (accept.valid && accept.vector >= `LIRQ_FIRST_VECTOR) begin
      state_d.pending[accept.vector]   = 1'b1;
      state_d.trig_mode[accept.vector] = accept.level;
    end

    if (eos_wr && serv_found) begin
      state_d.in_service[serv_top] = 1'b0;
    end

    if (bcast_go) begin
      state_d.bcast_valid  = 1'b1;
      state_d.bcast_vector = serv_top;
    end

    // masked by now gives spurious vector
    if (core_acknowledge_cycle) begin
      state_d.ack_valid = 1'b1;
      if (ack_take) begin
        // set wins: a vector raised again while taken stays pending
        state_d.pending[pend_top]    = accept.valid && (accept.vector == pend_top);
        state_d.in_service[pend_top] = 1'b1;
        state_d.ack_vector           = pend_top;
      end else begin
        state_d.ack_vector   = state_q.spur_vec;
        state_d.ack_spurious = 1'b1;
      end
    end

    // request recomputed every cycle, so it drops when masked or taken
    // forced low on completion so the next pick sees the cleared bit
    state_d.irq_req = deliverable && !core_acknowledge_cycle && !eos_wr;

    if (reg_req.wr) begin
      case (reg_req.addr)
        `LIRQ_OFS_TPR: begin
          state_d.task_priority_threshold = reg_req.wdata[7:0];
        end
        `LIRQ_OFS_SVR: begin
          state_d.spur_vec  = wvec;
          state_d.sw_enable = reg_req.wdata[`LIRQ_SVR_ENABLE];
          // focus bit reserved in newer variant
          // held in enable sense so the output is a plain flop
          state_d.focus_chk = NEW_VARIANT ? 1'b1 : !reg_req.wdata[`LIRQ_SVR_FOCUS];
          state_d.suppress  = SUPPRESS_SUPPORT && reg_req.wdata[`LIRQ_SVR_SUPPRESS];
        end
        // completion decoded above, its data dropped
        `LIRQ_OFS_EOS: begin
        end
        // version register is read-only
        `LIRQ_OFS_VERSION: begin
        end
        default: begin
        end
      endcase
    end

    if (reg_req.rd) begin
      state_d.rvalid = 1'b1;
      state_d.rdata  = 32'h0;
      case (reg_req.addr)
        `LIRQ_OFS_TPR: begin
          state_d.rdata[7:0] = state_q.task_priority_threshold;
        end
        `LIRQ_OFS_SVR: begin
          state_d.rdata[`LIRQ_SVR_VEC_MSB:`LIRQ_SVR_VEC_LSB] = state_q.spur_vec;
          state_d.rdata[`LIRQ_SVR_ENABLE]   = state_q.sw_enable;
          state_d.rdata[`LIRQ_SVR_FOCUS]    = !state_q.focus_chk;
          state_d.rdata[`LIRQ_SVR_SUPPRESS] = state_q.suppress;
        end
        `LIRQ_OFS_VERSION: begin
          state_d.rdata[7:0]                = VERSION_ID;
          state_d.rdata[`LIRQ_VER_SUPPRESS] = SUPPRESS_SUPPORT;
        end
        `LIRQ_OFS_EOS: begin
          state_d.rdata = 32'h0;
        end
        // unmapped reads also answer zero
        default: begin
        end
      endcase
    end

    // after the register write, so the alias wins a same-cycle threshold clash
    if (alias_req.wr || alias_req.rd) begin
      state_d.alias_done  = 1'b1;
      state_d.alias_fault = !alias_ok;
      state_d.alias_rdata = 64'h0;
      if (alias_ok && state_q.sw_enable) begin
        if (alias_req.wr) begin
          state_d.task_priority_threshold = {alias_req.wdata[3:0], 4'h0};
        end
        if (alias_req.rd) begin
          state_d.alias_rdata = {60'h0, state_q.task_priority_threshold[7:4]};
        end
      end
    end
  end

  // sync reset: every field to a constant
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q.pending      <= '0;
      state_q.in_service   <= '0;
      state_q.trig_mode    <= '0;
      state_q.task_priority_threshold          <= `LIRQ_RST_TPR;
      state_q.spur_vec     <= `LIRQ_RST_SPUR_VEC;
      state_q.sw_enable    <= `LIRQ_RST_ENABLE;
      state_q.focus_chk    <= !`LIRQ_RST_FOCUS;
      state_q.suppress     <= `LIRQ_RST_SUPPRESS;
      state_q.rdata        <= 32'h0;
      state_q.rvalid       <= 1'b0;
      state_q.alias_rdata  <= 64'h0;
      state_q.alias_done   <= 1'b0;
      state_q.alias_fault  <= 1'b0;
      state_q.irq_req      <= 1'b0;
      state_q.ack_vector   <= 8'h00;
      state_q.ack_valid    <= 1'b0;
      state_q.ack_spurious <= 1'b0;
      state_q.bcast_valid  <= 1'b0;
      state_q.bcast_vector <= 8'h00;
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rdata          = state_q.rdata;
  assign reg_rvalid         = state_q.rvalid;
  assign alias_rdata        = state_q.alias_rdata;
  assign alias_done         = state_q.alias_done;
  assign alias_fault        = state_q.alias_fault;
  assign core_interrupt_request = state_q.irq_req;
  assign ack_vector         = state_q.ack_vector;
  assign ack_valid          = state_q.ack_valid;
  assign ack_spurious       = state_q.ack_spurious;
  assign eos_bcast_valid    = state_q.bcast_valid;
  assign eos_bcast_vector   = state_q.bcast_vector;
  assign controller_enabled = state_q.sw_enable;
  assign focus_check_enable = state_q.focus_chk;

endmodule

// ==== lirq_chk_sva.sv ====
// port assertions for lirq_core
// bound from tb_top, one clk_sys domain
`timescale 1ns/10ps
`include "lirq_defs.svh"
module lirq_chk (
  input wire logic                         clk_sys,
  input wire logic                         sys_rst,
  input wire lirq_pkg::lirq_reg_req_type   reg_req,
  input wire logic [31:0]                  reg_rdata,
  input wire logic                         reg_rvalid,
  input wire lirq_pkg::lirq_alias_req_type alias_req,
  input wire logic [63:0]                  alias_rdata,
  input wire logic                         alias_done,
  input wire logic                         alias_fault,
  input wire logic                         core_acknowledge_cycle,
  input wire logic                         core_interrupt_request,
  input wire logic                         ack_valid,
  input wire logic                         eos_bcast_valid,
  input wire logic                         controller_enabled
);
  logic sup_q;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // shadow of the suppress bit, the block does not export it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sup_q <= 1'b0;
    end else if (reg_req.wr && reg_req.addr == `LIRQ_OFS_SVR) begin
      sup_q <= reg_req.wdata[`LIRQ_SVR_SUPPRESS];
    end
  end
  sequence svr_wr;
    reg_req.wr && reg_req.addr == `LIRQ_OFS_SVR;
  endsequence
  sequence quiet_eos_wr;
    reg_req.wr && reg_req.addr == `LIRQ_OFS_EOS && sup_q;
  endsequence
  chk_eos_reads_zero: assert property (
    reg_req.rd && reg_req.addr == `LIRQ_OFS_EOS |=> reg_rvalid && reg_rdata == 32'h0)
    else $error("eos read");
  chk_bcast_cause: assert property (
    eos_bcast_valid |-> $past(reg_req.wr && reg_req.addr == `LIRQ_OFS_EOS))
    else $error("stray broadcast");
  chk_bcast_quiet: assert property (quiet_eos_wr |=> !eos_bcast_valid)
    else $error("suppressed broadcast");
  chk_enable_bit: assert property (
    svr_wr |=> controller_enabled == $past(reg_req.wdata[`LIRQ_SVR_ENABLE]))
    else $error("enable bit");
  chk_power_up: assert property (disable iff (1'b0) sys_rst |=> controller_enabled)
    else $error("not enabled");
  chk_alias_priv: assert property (
    alias_req.rd && alias_req.cpl != 2'h0 |=> alias_done && alias_fault && alias_rdata == 64'h0)
    else $error("privilege");
  chk_alias_resv: assert property (
    alias_req.wr && alias_req.wdata[63:4] != 60'h0 |=> alias_done && alias_fault)
    else $error("reserved bits");
  chk_alias_zero_ext: assert property (alias_done |-> alias_rdata[63:4] == 60'h0)
    else $error("zero extension");
  chk_ack_answer: assert property (
    core_acknowledge_cycle |=> ack_valid && !core_interrupt_request ##1 !ack_valid)
    else $error("ack answer");
endmodule

// ==== lirq_cpu_model.sv ====
// core model: acknowledges a raised request after a lag
// drives only at the falling edge of clk_sys
`timescale 1ns/10ps
module lirq_cpu_model (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       core_interrupt_request,
  input  wire logic [2:0] lag,
  input  wire logic       hold,
  input  wire logic       kick,
  output logic            core_acknowledge_cycle
);
  logic [3:0] cnt;
  initial core_acknowledge_cycle = 1'b0;
  // kick acks even when masked, to provoke spurious
  always @(negedge clk_sys) begin
    core_acknowledge_cycle <= 1'b0;
    cnt <= 4'h0;
    if (kick) begin
      core_acknowledge_cycle <= 1'b1;
    end else if (!sys_rst && !hold && core_interrupt_request && !core_acknowledge_cycle) begin
      cnt <= cnt + 4'h1;
      if (cnt == {1'b0, lag}) core_acknowledge_cycle <= 1'b1;
    end
  end
endmodule

// ==== tb_top.sv ====
// bench for lirq_core against a bit-array model
// core model acknowledges; checker bound below
`timescale 1ns/10ps
`include "lirq_defs.svh"
module tb_top;
  logic                         clk_sys = 1'b0;
  logic                         sys_rst = 1'b1;
  lirq_pkg::lirq_reg_req_type   reg_req = '0;
  lirq_pkg::lirq_alias_req_type alias_req = '0;
  lirq_pkg::lirq_accept_type    accept = '0;
  logic [2:0]                   lag = 3'h0;
  logic                         hold = 1'b0;
  logic                         kick = 1'b0;
  logic [31:0]                  reg_rdata;
  logic [63:0]                  alias_rdata;
  logic [7:0]                   ack_vector, eos_bcast_vector, mtpr = 8'h0, mspur = 8'hff;
  logic                         reg_rvalid, alias_done, alias_fault, core_acknowledge_cycle;
  logic                         core_interrupt_request, ack_valid, ack_spurious, eos_bcast_valid;
  logic                         controller_enabled, focus_check_enable, men = 1'b1, msup = 1'b0;
  logic [255:0]                 mp = '0, mi = '0, mt = '0;
  int                           miscompares = 0, tests_run = 0;

  lirq_core dut (.*);
  lirq_cpu_model cpu (.*);

  always #5 clk_sys = ~clk_sys;

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic int top(logic [255:0] v);
    top = 0;
    for (int i = 16; i < 256; i++)
      if (v[i]) top = i;
  endfunction

  task automatic rg(input bit w, input logic [31:0] a, input logic [31:0] d,
                    input logic [31:0] e);
    @(negedge clk_sys);
    reg_req = '{w, !w, a, d};
    if (w && a == `LIRQ_OFS_TPR) mtpr = d[7:0];
    if (w && a == `LIRQ_OFS_SVR) {msup, men, mspur} = {d[12], d[8], d[7:0]};
    @(negedge clk_sys);
    reg_req = '0;
    if (!w) chk({reg_rvalid, reg_rdata}, {1'b1, e});
  endtask

  task automatic al(input bit w, input logic [1:0] c, input logic [63:0] d, input bit f,
                    input logic [63:0] e);
    @(negedge clk_sys);
    alias_req = '{w, !w, c, d};
    if (w && !f && men) mtpr = {d[3:0], 4'h0};
    @(negedge clk_sys);
    alias_req = '0;
    chk({alias_done, alias_fault, w ? 64'h0 : alias_rdata}, {1'b1, f, e});
  endtask

  task automatic ac(input logic [7:0] v, input bit l);
    @(negedge clk_sys);
    accept = '{1'b1, v, l};
    mp[v] = 1'b1;
    mt[v] = l;
    @(negedge clk_sys);
    accept = '0;
    repeat (14) @(negedge clk_sys);
  endtask

  task automatic eo;
    int i;
    bit b;
    i = top(mi);
    b = mt[i] && !msup;
    rg(1'b1, `LIRQ_OFS_EOS, $urandom, 32'h0);
    chk({eos_bcast_valid, eos_bcast_valid ? eos_bcast_vector : 8'h0}, {b, b ? i[7:0] : 8'h0});
    mi[i] = 1'b0;
    repeat (14) @(negedge clk_sys);
  endtask

  // class compare against the higher of threshold and top in-service
  always @(negedge clk_sys) begin : mon
    int p;
    int c;
    bit s;
    if (!sys_rst && ack_valid === 1'b1) begin
      p = top(mp);
      c = top(mi) > mtpr ? top(mi) : mtpr;
      s = !(men && p > 0 && p / 16 > c / 16);
      chk({ack_spurious, ack_vector}, {s, s ? mspur : p[7:0]});
      if (!s) begin
        mp[p] = 1'b0;
        mi[p] = 1'b1;
      end
    end
  end

  initial begin
    #100us;
    miscompares++;
    end_sim;
  end

  initial begin
    logic [7:0] v;
    void'($urandom(32'he6d54a33));
    repeat (6) @(negedge clk_sys);
    sys_rst = 1'b0;
    chk({controller_enabled, focus_check_enable}, 2'b11);
    rg(1'b0, `LIRQ_OFS_SVR, 32'h0, 32'h1ff);
    rg(1'b0, `LIRQ_OFS_TPR, 32'h0, 32'h0);
    rg(1'b0, `LIRQ_OFS_VERSION, 32'h0, 32'h01000015);
    rg(1'b0, `LIRQ_OFS_EOS, 32'h0, 32'h0);
    rg(1'b0, 32'hfee00ffc, 32'h0, 32'h0);
    $display("reset test done");
    for (int c = 0; c < 4; c++) begin
      al(1'b1, 2'(c), 64'h8, c != 0, 64'h0);
      al(1'b0, 2'(c), 64'h0, c != 0, {60'h0, c == 0 ? 4'h8 : 4'h0});
    end
    al(1'b1, 2'h0, 64'h1f, 1'b1, 64'h0);
    repeat (3) begin
      v = 8'($urandom_range(15, 0));
      al(1'b1, 2'h0, {56'h0, v}, 1'b0, 64'h0);
      rg(1'b0, `LIRQ_OFS_TPR, 32'h0, {24'h0, v[3:0], 4'h0});
    end
    $display("alias test done");
    rg(1'b1, `LIRQ_OFS_TPR, 32'h80, 32'h0);
    ac(8'h8c, 1'b1);
    chk(core_interrupt_request, 1'b0);
    ac(8'h95, 1'b0);
    eo;
    rg(1'b1, `LIRQ_OFS_TPR, 32'h0, 32'h0);
    repeat (14) @(negedge clk_sys);
    eo;
    $display("threshold test done");
    for (int n = 0; n < 24; n++) begin
      lag <= 3'($urandom);
      v = 8'($urandom_range(255, 16));
      if (v != mspur) ac(v, 1'($urandom));
      if ($urandom_range(1, 0) == 1) eo;
    end
    for (int k = 0; k < 48 && (mi != '0 || mp != '0); k++) eo;
    $display("random test done");
    rg(1'b1, `LIRQ_OFS_SVR, 32'h133a, 32'h0);
    rg(1'b0, `LIRQ_OFS_SVR, 32'h0, 32'h113a);
    chk(focus_check_enable, 1'b1);
    ac(8'h77, 1'b1);
    eo;
    hold <= 1'b1;
    ac(8'hc3, 1'b1);
    rg(1'b1, `LIRQ_OFS_TPR, 32'hf0, 32'h0);
    kick <= 1'b1;
    @(negedge clk_sys);
    kick <= 1'b0;
    repeat (4) @(negedge clk_sys);
    hold <= 1'b0;
    rg(1'b1, `LIRQ_OFS_TPR, 32'h0, 32'h0);
    repeat (14) @(negedge clk_sys);
    eo;
    $display("spurious test done");
    rg(1'b1, `LIRQ_OFS_SVR, 32'h00ff, 32'h0);
    chk(controller_enabled, 1'b0);
    ac(8'h50, 1'b0);
    chk(core_interrupt_request, 1'b0);
    al(1'b1, 2'h0, 64'h9, 1'b0, 64'h0);
    al(1'b0, 2'h0, 64'h0, 1'b0, 64'h0);
    rg(1'b0, `LIRQ_OFS_TPR, 32'h0, {24'h0, mtpr});
    rg(1'b1, `LIRQ_OFS_SVR, 32'h01ff, 32'h0);
    repeat (14) @(negedge clk_sys);
    $display("disable test done");
    end_sim;
  end
endmodule

bind lirq_core lirq_chk u_chk (.*);
